// ==== lpct_map.svh ====
// Register map, field positions, reset values and timing counts
`ifndef LPCT_MAP_SVH
`define LPCT_MAP_SVH
// ----------------------------------------
// Bus geometry
// ----------------------------------------
`define LPCT_AW 10
`define LPCT_IDX_HI 9
`define LPCT_IDX_LO 2
`define LPCT_CW 41
// ----------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------
`define LPCT_IDX_LP 8'h6e
`define LPCT_IDX_CTRL 8'h70
`define LPCT_IDX_STAT 8'h71
`define LPCT_IDX_GAIN 8'h7a
`define LPCT_IDX_REF 8'h7c
`define LPCT_IDX_TERM 8'h7e
// ----------------------------------------
// Field positions
// ----------------------------------------
`define LPCT_F_SLEEP_HI 7
`define LPCT_F_SLEEP_LO 5
`define LPCT_F_SETTLE_HI 4
`define LPCT_F_SETTLE_LO 3
`define LPCT_F_TRIGMODE 1
`define LPCT_F_LPEN 0
`define LPCT_F_BGEN 0
`define LPCT_F_SRCSEL 1
`define LPCT_F_SOFT 2
`define LPCT_F_REF_HI 3
// ----------------------------------------
// Reset values
// ----------------------------------------
`define LPCT_RST_SLEEP 3'h4
`define LPCT_RST_SETTLE 2'h1
`define LPCT_RST_SOFT 1'h1
`define LPCT_RESP_OKAY 2'h0
`define LPCT_RESP_SLVERR 2'h2
// ----------------------------------------
// Intervals in sample clock periods
// ----------------------------------------
`define LPCT_P_1152 41'h480
`define LPCT_P_4194432 41'h400080
`define LPCT_P_33554560 41'h2000080
`define LPCT_P_268435584 41'h10000080
`define LPCT_P_2147483776 41'h80000080
`define LPCT_P_17179869312 41'h400000080
`define LPCT_P_137438953600 41'h2000000080
`define LPCT_P_1099511627904 41'h10000000080
`endif

// ==== lpct_pkg.sv ====
// Types shared by the low-power calibration and trim register block
package lpct_pkg;
`include "lpct_map.svh"

   typedef enum logic [1:0] {
      LPCT_IDLE = 2'b00,
      LPCT_SLEEP = 2'b01,
      LPCT_SETTLE = 2'b10,
      LPCT_CAL = 2'b11
   } lpct_state_t;

   typedef enum logic [2:0] {
      LPCT_SEL_NONE = 3'b000,
      LPCT_SEL_LP = 3'b001,
      LPCT_SEL_CTRL = 3'b010,
      LPCT_SEL_STAT = 3'b011,
      LPCT_SEL_GAIN = 3'b100,
      LPCT_SEL_REF = 3'b101,
      LPCT_SEL_TERM = 3'b110
   } lpct_sel_t;

   typedef struct packed {
      lpct_state_t state;
      logic [`LPCT_CW-1:0] count;
      logic [2:0] sleep_sel;
      logic [1:0] settle_sel;
      logic trig_mode;
      logic lowpower_cal_enable;
      logic bg_en;
      logic src_sel;
      logic soft_trig;
      logic [7:0] gain;
      logic [3:0] refadj;
      logic [7:0] term;
      logic awready;
      logic wready;
      logic have_aw;
      logic have_w;
      logic [7:0] aw_idx;
      logic [7:0] wdata;
      logic wlane0;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic sleep_out;
      logic cal_out;
   } lpct_state_s_t;
endpackage

// ==== lpct_regs.sv ====
// Low-power background calibration control and factory trim registers
`timescale 1ns/1ns
`include "lpct_map.svh"
module lpct_regs
   import lpct_pkg::*;
#(
   parameter logic [`LPCT_CW-1:0] SLEEP_PERIODS [0:7] = '{
      `LPCT_P_1152,
      `LPCT_P_4194432,
      `LPCT_P_33554560,
      `LPCT_P_268435584,
      `LPCT_P_2147483776,
      `LPCT_P_17179869312,
      `LPCT_P_137438953600,
      `LPCT_P_1099511627904
   },
   parameter logic [`LPCT_CW-1:0] SETTLE_PERIODS [0:3] = '{
      `LPCT_P_1152,
      `LPCT_P_33554560,
      `LPCT_P_268435584,
      `LPCT_P_2147483776
   }
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   // AXI4-Lite write address and data
   input wire logic [`LPCT_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [`LPCT_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Factory fuse values
   input wire logic [7:0] fuse_gain,
   input wire logic [3:0] fuse_reference,
   input wire logic [7:0] fuse_termination_a,
   // Calibration side
   input wire logic sample_tick,
   input wire logic calibration_trigger_pin,
   input wire logic cal_done,
   output logic offline_core_sleep,
   output logic calibrate_req,
   // Trim outputs to the analog cores
   output logic [7:0] core_gain_trim,
   output logic [3:0] reference_trim,
   output logic [7:0] input_a_termination_trim
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Word index to register select, shared by both bus paths
   function automatic lpct_sel_t lpct_decode(input logic [7:0] idx);
      lpct_sel_t s;
      s = LPCT_SEL_NONE;
      unique case (idx)
         `LPCT_IDX_LP: s = LPCT_SEL_LP;
         `LPCT_IDX_CTRL: s = LPCT_SEL_CTRL;
         `LPCT_IDX_STAT: s = LPCT_SEL_STAT;
         `LPCT_IDX_GAIN: s = LPCT_SEL_GAIN;
         `LPCT_IDX_REF: s = LPCT_SEL_REF;
         `LPCT_IDX_TERM: s = LPCT_SEL_TERM;
         default: s = LPCT_SEL_NONE;
      endcase
      return s;
   endfunction

   // Last count value of an interval: the Nth tick ends it, so N minus one
   function automatic logic [`LPCT_CW-1:0] lpct_last(input logic [`LPCT_CW-1:0] period);
      return period - `LPCT_CW'(1);
   endfunction

   // ----------------------------------------
   // State and decode signals
   // ----------------------------------------
   // Whole block state, current and next
   lpct_state_s_t r_reg;
   lpct_state_s_t r_next;
   // Derived controls and bus decode
   logic active;
   logic trig;
   logic [`LPCT_CW-1:0] sleep_last;
   logic [`LPCT_CW-1:0] settle_last;
   lpct_sel_t wsel;
   lpct_sel_t rsel;
   logic [7:0] ar_idx;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   // Qualified enable and selected trigger
   assign active = r_reg.lowpower_cal_enable & r_reg.bg_en;
   assign trig = r_reg.src_sel ? calibration_trigger_pin : r_reg.soft_trig;
   // Interval end points follow the current selects
   assign sleep_last = lpct_last(SLEEP_PERIODS[r_reg.sleep_sel]);
   assign settle_last = lpct_last(SETTLE_PERIODS[r_reg.settle_sel]);
   // Register selects for the held write and the offered read
   assign wsel = lpct_decode(r_reg.aw_idx);
   assign ar_idx = s_axi_araddr[`LPCT_IDX_HI:`LPCT_IDX_LO];
   assign rsel = lpct_decode(ar_idx);

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   // Fills the whole next state: reset, bus, registers, sequencer
   always_comb begin
      r_next = r_reg;
      if (!reset_n) begin
         r_next = '0;
         r_next.state = LPCT_IDLE;
         r_next.sleep_sel = `LPCT_RST_SLEEP;
         r_next.settle_sel = `LPCT_RST_SETTLE;
         r_next.soft_trig = `LPCT_RST_SOFT;
         // Trims take the factory fuse values, never a constant
         r_next.gain = fuse_gain;
         r_next.refadj = fuse_reference;
         r_next.term = fuse_termination_a;
      end else if (ce) begin
         // Response channels retire on their handshakes
         if (r_reg.bvalid && s_axi_bready) begin
            r_next.bvalid = 1'b0;
         end
         if (r_reg.rvalid && s_axi_rready) begin
            r_next.rvalid = 1'b0;
         end
         // Capture write address and data in either order
         if (s_axi_awvalid && r_reg.awready) begin
            r_next.have_aw = 1'b1;
            r_next.aw_idx = s_axi_awaddr[`LPCT_IDX_HI:`LPCT_IDX_LO];
         end
         if (s_axi_wvalid && r_reg.wready) begin
            r_next.have_w = 1'b1;
            r_next.wdata = s_axi_wdata[7:0];
            r_next.wlane0 = s_axi_wstrb[0];
         end
         // Commit a write once both halves are held
         if (r_reg.have_aw && r_reg.have_w && !r_reg.bvalid) begin
            r_next.have_aw = 1'b0;
            r_next.have_w = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp = (wsel == LPCT_SEL_NONE) ? `LPCT_RESP_SLVERR : `LPCT_RESP_OKAY;
            if (r_reg.wlane0) begin
               unique case (wsel)
                  LPCT_SEL_LP: begin
                     r_next.sleep_sel = r_reg.wdata[`LPCT_F_SLEEP_HI:`LPCT_F_SLEEP_LO];
                     r_next.settle_sel = r_reg.wdata[`LPCT_F_SETTLE_HI:`LPCT_F_SETTLE_LO];
                     r_next.trig_mode = r_reg.wdata[`LPCT_F_TRIGMODE];
                     r_next.lowpower_cal_enable = r_reg.wdata[`LPCT_F_LPEN];
                  end
                  LPCT_SEL_CTRL: begin
                     r_next.bg_en = r_reg.wdata[`LPCT_F_BGEN];
                     r_next.src_sel = r_reg.wdata[`LPCT_F_SRCSEL];
                     r_next.soft_trig = r_reg.wdata[`LPCT_F_SOFT];
                  end
                  LPCT_SEL_GAIN: r_next.gain = r_reg.wdata;
                  LPCT_SEL_REF: r_next.refadj = r_reg.wdata[`LPCT_F_REF_HI:0];
                  LPCT_SEL_TERM: r_next.term = r_reg.wdata;
                  default: r_next.gain = r_reg.gain;
               endcase
            end
         end
         // Read: one request at a time, data held until taken
         if (s_axi_arvalid && r_reg.arready) begin
            r_next.rvalid = 1'b1;
            r_next.rresp = (rsel == LPCT_SEL_NONE) ? `LPCT_RESP_SLVERR : `LPCT_RESP_OKAY;
            r_next.rdata = '0;
            unique case (rsel)
               LPCT_SEL_LP: begin
                  r_next.rdata[`LPCT_F_SLEEP_HI:`LPCT_F_SLEEP_LO] = r_reg.sleep_sel;
                  r_next.rdata[`LPCT_F_SETTLE_HI:`LPCT_F_SETTLE_LO] = r_reg.settle_sel;
                  r_next.rdata[`LPCT_F_TRIGMODE] = r_reg.trig_mode;
                  r_next.rdata[`LPCT_F_LPEN] = r_reg.lowpower_cal_enable;
               end
               LPCT_SEL_CTRL: begin
                  r_next.rdata[`LPCT_F_BGEN] = r_reg.bg_en;
                  r_next.rdata[`LPCT_F_SRCSEL] = r_reg.src_sel;
                  r_next.rdata[`LPCT_F_SOFT] = r_reg.soft_trig;
               end
               LPCT_SEL_STAT: begin
                  r_next.rdata[1:0] = r_reg.state;
                  r_next.rdata[`LPCT_F_SOFT] = trig;
               end
               LPCT_SEL_GAIN: r_next.rdata[7:0] = r_reg.gain;
               LPCT_SEL_REF: r_next.rdata[`LPCT_F_REF_HI:0] = r_reg.refadj;
               LPCT_SEL_TERM: r_next.rdata[7:0] = r_reg.term;
               default: r_next.rdata = '0;
            endcase
         end
         // Sleep, settle, calibrate sequencer
         unique case (r_reg.state)
            LPCT_IDLE: begin
               r_next.count = '0;
               if (active) begin
                  r_next.state = LPCT_SLEEP;
               end
            end
            LPCT_SLEEP: begin
               if (!active) begin
                  r_next.state = LPCT_IDLE;
               end else if (r_reg.trig_mode) begin
                  // Trigger mode ignores the counted interval
                  r_next.count = '0;
                  if (!trig) begin
                     r_next.state = LPCT_SETTLE;
                  end
               end else if (sample_tick) begin
                  // Greater-or-equal ends promptly when the select shrinks mid-count
                  if (r_reg.count >= sleep_last) begin
                     r_next.state = LPCT_SETTLE;
                     r_next.count = '0;
                  end else begin
                     r_next.count = r_reg.count + 1'b1;
                  end
               end
            end
            LPCT_SETTLE: begin
               if (!active) begin
                  r_next.state = LPCT_IDLE;
               end else if (sample_tick) begin
                  if (r_reg.count >= settle_last) begin
                     r_next.state = LPCT_CAL;
                     r_next.count = '0;
                  end else begin
                     r_next.count = r_reg.count + 1'b1;
                  end
               end
            end
            LPCT_CAL: begin
               if (!active) begin
                  r_next.state = LPCT_IDLE;
               end else if (cal_done) begin
                  r_next.state = LPCT_SLEEP;
               end
            end
         endcase
         // Ready flags and core controls follow the next state
         r_next.awready = !r_next.have_aw && !r_next.bvalid;
         r_next.wready = !r_next.have_w && !r_next.bvalid;
         r_next.arready = !r_next.rvalid;
         r_next.sleep_out = (r_next.state == LPCT_SLEEP);
         r_next.cal_out = (r_next.state == LPCT_CAL);
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   // Registers the whole state
   // Reset acts through the next state, so it applies even with ce low
   always_ff @(posedge clk) begin
      r_reg <= r_next;
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Outputs straight from the state register
   assign s_axi_awready = r_reg.awready;
   assign s_axi_wready = r_reg.wready;
   assign s_axi_bvalid = r_reg.bvalid;
   assign s_axi_bresp = r_reg.bresp;
   assign s_axi_arready = r_reg.arready;
   assign s_axi_rvalid = r_reg.rvalid;
   assign s_axi_rdata = r_reg.rdata;
   assign s_axi_rresp = r_reg.rresp;
   assign offline_core_sleep = r_reg.sleep_out;
   assign calibrate_req = r_reg.cal_out;
   assign core_gain_trim = r_reg.gain;
   assign reference_trim = r_reg.refadj;
   assign input_a_termination_trim = r_reg.term;

endmodule

// ==== lpct_chk.sv ====
// Port assertions for the calibration and trim register block
`timescale 1ns/1ns
module lpct_chk (
   // Clock, reset, enable
   input logic clk,
   input logic reset_n,
   input logic ce,
   // Bus handshakes
   input logic s_axi_awvalid,
   input logic s_axi_awready,
   input logic s_axi_wvalid,
   input logic s_axi_wready,
   input logic [1:0] s_axi_bresp,
   input logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic s_axi_rvalid,
   input logic s_axi_rready,
   // Sequencer and trims
   input logic sample_tick,
   input logic cal_done,
   input logic offline_core_sleep,
   input logic calibrate_req,
   input logic [7:0] core_gain_trim
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // ----
   // Write address and data taken together, answer two cycles later
   // ----
   sequence s_wtake;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_bans;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   property p_wr_answer;
      s_wtake |=> s_bans;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("late write answer");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_rd_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("late read answer");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   property p_r_upper;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
   endproperty
   a_r_upper: assert property (p_r_upper) else $error("upper read bits set");
   // Sleep and calibration never overlap
   property p_excl;
      !(offline_core_sleep && calibrate_req);
   endproperty
   a_excl: assert property (p_excl) else $error("sleep during calibration");
   property p_cal_end;
      ce && calibrate_req && cal_done |=> !calibrate_req;
   endproperty
   a_cal_end: assert property (p_cal_end) else $error("calibration not ended");
   // Settling ends only on a sample period
   property p_cal_tick;
      $rose(calibrate_req) |-> $past(sample_tick);
   endproperty
   a_cal_tick: assert property (p_cal_tick) else $error("calibration without tick");
   property p_trim_hold;
      !$rose(s_axi_bvalid) |-> $stable(core_gain_trim);
   endproperty
   a_trim_hold: assert property (p_trim_hold) else $error("gain trim moved");
endmodule
bind lpct_regs lpct_chk u_chk (
   .clk(clk), .reset_n(reset_n), .ce(ce), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sample_tick(sample_tick),
   .cal_done(cal_done), .offline_core_sleep(offline_core_sleep),
   .calibrate_req(calibrate_req), .core_gain_trim(core_gain_trim));

// ==== tb.sv ====
// Self-checking bench for the calibration and trim register block
`timescale 1ns/1ns
module tb;
   localparam logic [40:0] SLP [0:7] = '{41'h2, 41'h3, 41'h4, 41'h5, 41'h6, 41'h7, 41'h8, 41'h9};
   localparam logic [40:0] STL [0:3] = '{41'h2, 41'h3, 41'h4, 41'h5};
   localparam logic [9:0] LP = 10'h1b8;
   localparam logic [9:0] CTRL = 10'h1c0;
   typedef struct {
      logic [9:0] a;
      logic [31:0] d;
      logic [3:0] s;
      logic [31:0] q;
      logic [1:0] r;
   } lpct_row_t;
   // ----
   // Stimulus, observed outputs, expectations
   // ----
   logic clk = 1'h0, reset_n = 1'h0, ce = 1'h1, awv = 1'h0, wv = 1'h0, br = 1'h0;
   logic arv = 1'h0, rr = 1'h0, tick = 1'h0, pin = 1'h0, done = 1'h0, mon = 1'h0;
   logic [9:0] awa = 10'h0, ara = 10'h0;
   logic [31:0] wd = 32'h0, rd, q;
   logic [3:0] ws = 4'h0, fr = 4'h9, rt;
   logic [1:0] bresp, rresp, r;
   logic awr, wr, bv, arr, rv, slp, cal;
   logic [7:0] fg = 8'h5a, ft = 8'hc3, gt, tt;
   int failures = 0, check_count = 0, ns, nt, n;
   lpct_row_t rows [0:8] = '{
      '{10'h1e8, 32'ha5, 4'hf, 32'ha5, 2'h0}, '{10'h1e8, 32'h11, 4'h0, 32'ha5, 2'h0},
      '{10'h1f0, 32'hff, 4'h1, 32'h0f, 2'h0}, '{10'h1f8, 32'h3c, 4'h1, 32'h3c, 2'h0},
      '{10'h1b8, 32'hfb, 4'h1, 32'hfb, 2'h0}, '{10'h1b8, 32'h88, 4'h1, 32'h88, 2'h0},
      '{10'h1c0, 32'h06, 4'h1, 32'h06, 2'h0}, '{10'h1c4, 32'hff, 4'h1, 32'h0, 2'h0},
      '{10'h004, 32'h12, 4'h1, 32'h0, 2'h2}};
   lpct_regs #(.SLEEP_PERIODS(SLP), .SETTLE_PERIODS(STL)) uut (
      .clk(clk), .reset_n(reset_n), .ce(ce), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
      .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .fuse_gain(fg),
      .fuse_reference(fr), .fuse_termination_a(ft), .sample_tick(tick),
      .calibration_trigger_pin(pin), .cal_done(done), .offline_core_sleep(slp),
      .calibrate_req(cal), .core_gain_trim(gt), .reference_trim(rt),
      .input_a_termination_trim(tt));
   // Clock and a sample tick every second cycle
   always #5 clk = ~clk;
   always @(posedge clk) tick <= ~tick;
   // Count ticks spent sleeping and settling
   always @(posedge clk) begin
      if (mon && tick && slp) ns++;
      else if (mon && tick && !cal) nt++;
   end
   // ----
   // Tasks
   // ----
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Bus write; ready for the answer once it shows, to exercise waiting
   task automatic axw(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk);
      awa <= a;
      wd <= d;
      ws <= s;
      awv <= 1'h1;
      wv <= 1'h1;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'h0;
         if (wr) wv <= 1'h0;
         if (bv && !br) br <= 1'h1;
      end while (!(bv && br));
      r = bresp;
      br <= 1'h0;
   endtask
   task automatic axr(input logic [9:0] a);
      @(posedge clk);
      ara <= a;
      arv <= 1'h1;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'h0;
         if (rv && !rr) rr <= 1'h1;
      end while (!(rv && rr));
      q = rd;
      r = rresp;
      rr <= 1'h0;
   endtask
   task automatic wait_for(input logic want_slp);
      for (n = 0; n < 300 && (want_slp ? !slp : !cal); n++) @(negedge clk);
   endtask
   // One autonomous round with sleep code c and settle code c mod 4
   task automatic run_lp(input logic [2:0] c);
      axw(LP, 32'h0, 4'h1);
      axw(LP, {24'h0, c, c[1:0], 3'h1}, 4'h1);
      wait_for(1'h1);
      ns = 0;
      nt = 0;
      mon = 1'h1;
      wait_for(1'h0);
      mon = 1'h0;
      chk(ns, 32'(c) + 32'h2);
      chk(nt, 32'(c[1:0]) + 32'h2);
      @(posedge clk);
      done <= 1'h1;
      @(posedge clk);
      done <= 1'h0;
      @(negedge clk);
      chk({slp, cal}, 2'h2);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      #200000;
      failures++;
      $display("mismatch at %0t: watchdog expired", $time);
      end_of_test;
   end
   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      reset_n <= 1'h1;
      @(negedge clk);
      chk(gt, 8'h5a);
      chk({rt, tt}, 12'h9c3);
      axr(LP);
      chk(q, 32'h88);
      $display("reset test done");
      for (int i = 0; i < 9; i++) begin
         axw(rows[i].a, rows[i].d, rows[i].s);
         chk(r, rows[i].r);
         axr(rows[i].a);
         chk(q, rows[i].q);
         chk(r, rows[i].r);
      end
      chk({gt, rt, tt}, 20'ha5f3c);
      $display("table test done");
      axw(CTRL, 32'h5, 4'h1);
      for (int c = 0; c < 8; c++) run_lp(3'(c));
      $display("sequencer test done");
      axw(LP, 32'h88, 4'h1);
      axw(CTRL, 32'h4, 4'h1);
      axw(LP, 32'h8b, 4'h1);
      repeat (30) @(negedge clk);
      chk(slp, 1'h0);
      axw(CTRL, 32'h5, 4'h1);
      repeat (30) @(negedge clk);
      chk(slp, 1'h1);
      @(posedge clk);
      pin <= 1'h1;
      axw(CTRL, 32'h3, 4'h1);
      repeat (30) @(negedge clk);
      chk(slp, 1'h1);
      @(posedge clk);
      pin <= 1'h0;
      @(posedge clk);
      @(negedge clk);
      chk(slp, 1'h0);
      wait_for(1'h0);
      chk(cal, 1'h1);
      $display("trigger test done");
      // Frozen clock enable: a done pulse is ignored, calibration stays
      @(posedge clk);
      ce <= 1'h0;
      done <= 1'h1;
      repeat (3) @(posedge clk);
      ce <= 1'h1;
      done <= 1'h0;
      @(negedge clk);
      chk(cal, 1'h1);
      $display("clock enable test done");
      // Second reset reloads fresh fuse values over the written trims
      @(posedge clk);
      fg <= 8'h3e;
      fr <= 4'h6;
      ft <= 8'h71;
      reset_n <= 1'h0;
      repeat (2) @(posedge clk);
      reset_n <= 1'h1;
      @(negedge clk);
      chk({gt, rt, tt}, 20'h3e671);
      chk({slp, cal}, 2'h0);
      axr(LP);
      chk(q, 32'h88);
      $display("second reset test done");
      end_of_test;
   end
endmodule
